// [atc_consts.svh]
// Offsets, field positions, reset values and timing counts of the
// converter/touch controller. Definitions only; included by bare name.
`ifndef ATC_CONSTS_SVH
`define ATC_CONSTS_SVH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define ATC_OFF_CTRL 8'h00
`define ATC_OFF_CDIV 8'h04
`define ATC_OFF_IDIV 8'h08
`define ATC_OFF_WDOG 8'h0c
`define ATC_OFF_STAT 8'h10
`define ATC_OFF_TX 8'h14
`define ATC_OFF_TY 8'h18
`define ATC_OFF_RES0 8'h20
`define ATC_OFF_RES3 8'h2c

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define ATC_CTRL_SINGLE_GO 0
`define ATC_CTRL_CONT_EN 1
`define ATC_CTRL_TOUCH_EN 2
`define ATC_CTRL_FIVE_WIRE 3
`define ATC_CTRL_SCAN_GO 4
`define ATC_CTRL_WD_EN 5
`define ATC_CTRL_SINGLE_LSB 8
`define ATC_CTRL_CONT_LSB 12
`define ATC_CTRL_SCAN_LSB 16
`define ATC_WDOG_HI_LSB 16
`define ATC_STAT_PRESS 0
`define ATC_STAT_RELEASE 1
`define ATC_STAT_WDOG 2
`define ATC_STAT_REFUSED 3
`define ATC_STAT_PEN 4
`define ATC_STAT_BUSY 5
`define ATC_VALID_BIT 31

// ----------------------------------------------------------------------
// Reset values and channel map
// ----------------------------------------------------------------------
`define ATC_DIV_RST 16'h0000
`define ATC_WD_LO_RST 10'h000
`define ATC_WD_HI_RST 10'h3ff
`define ATC_CH_XP 2'h0
`define ATC_CH_YP 2'h1

// ----------------------------------------------------------------------
// Timing: clock rate, top rates, least divisors (rounded up)
// ----------------------------------------------------------------------
`define ATC_CLK_HZ 125000000
`define ATC_CONV_MAX_HZ 16000000
`define ATC_INTV_MAX_HZ 1000000
`define ATC_CONV_MIN_DIV 16'((`ATC_CLK_HZ + `ATC_CONV_MAX_HZ - 1) / `ATC_CONV_MAX_HZ)
`define ATC_INTV_MIN_DIV 16'((`ATC_CLK_HZ + `ATC_INTV_MAX_HZ - 1) / `ATC_INTV_MAX_HZ)

`endif

// [atc_conv_model.sv]
// Converter macro and DMA sink model facing the controller.
// Assumes one conversion at a time and the 125 MHz system clock.
`timescale 1ns/10ps

module atc_conv_model
(
    // Clock
    input wire logic clock,
    // Converter side
    input wire logic conv_start,
    input wire logic [1:0] conv_chan,
    output logic conv_done,
    output logic [9:0] conv_data,
    // DMA side
    input wire logic dma_req,
    output logic dma_ack
);
    logic [2:0] cnt_reg = 3'h0;
    logic ack_reg = 1'b0;

    // Answer four cycles after each start
    always_ff @(posedge clock)
    begin
        cnt_reg <= conv_start ? 3'h4 : (cnt_reg != 3'h0 ? cnt_reg - 3'h1 : 3'h0);
    end
    assign conv_done = (cnt_reg == 3'h1);
    // Off-strobe data inverted so stale values never look valid
    assign conv_data = conv_done ? {conv_chan, 8'ha5} : {~conv_chan, 8'h5a};
    // Take each DMA word one cycle after it appears
    always_ff @(posedge clock)
    begin
        ack_reg <= dma_req & ~ack_reg;
    end
    assign dma_ack = ack_reg;
endmodule : atc_conv_model

// [atc_pkg.sv]
// Types shared by the converter/touch controller files.
// Assumes nothing of its surroundings.
package atc_pkg;

    // Sequencer states
    typedef enum logic [1:0] {ST_IDLE, ST_WAIT} atc_state_t;

    // Kind of conversion in flight
    typedef enum logic [2:0] {JOB_SINGLE, JOB_SCAN, JOB_CONT, JOB_TOUCH_X, JOB_TOUCH_Y} atc_job_t;

endpackage : atc_pkg

// [atc_rate_div.sv]
// Rate divider: one-cycle enable pulse every div cycles, never faster
// than min_div cycles. Assumes a single 125 MHz clock, sync reset.
`timescale 1ns/10ps
`include "atc_consts.svh"

module atc_rate_div
(
    // Clock and reset
    input wire logic clock,
    input wire logic srst,
    // Settings
    input wire logic [15:0] div,
    input wire logic [15:0] min_div,
    // Enable pulse
    output logic tick
);

    logic [15:0] cnt_reg;
    logic [15:0] eff;

    // ------------------------------------------------------------------
    // Divider
    // ------------------------------------------------------------------

    // Clamp keeps a careless setting from overrunning the macro
    assign eff = (div < min_div) ? min_div : div;

    // Zero divisor stops the rate altogether
    always_ff @(posedge clock)
    begin
        if (srst || div == 16'h0000)
        begin
            cnt_reg <= 16'h0000;
            tick <= 1'b0;
        end
        else if (cnt_reg >= eff - 16'h0001)
        begin
            cnt_reg <= 16'h0000;
            tick <= 1'b1;
        end
        else
        begin
            cnt_reg <= cnt_reg + 16'h0001;
            tick <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking @(posedge clock); endclocking
    default disable iff (srst);

    tick_spacing_a: assert property (tick |=> !tick [*7])
        else $error("divider pulses closer than the least spacing");

    cov_tick_c: cover property (tick ##1 !tick [*7] ##1 tick);

endmodule : atc_rate_div

// [atc_top.sv]
// Converter and touch-panel controller: sequences a four-channel 10-bit
// converter. Assumes the converter answers each start with one done
// pulse, and that pen_down and bus strobes are synchronous to clock.
//
// Operation
// - Four analog channels, each result is ten bits wide.
// - Converter clock enable programmable from stopped up to 16 MHz.
// - Single and continuous modes; touch runs as special continuous mode.
// - Continuous results leave by DMA; touch coordinates never use DMA.
// - Spacing of continuous conversions programmable from stopped up to 1 MHz.
// - Single requests still served on channels continuous mode leaves free.
// - Touch mode raises one interrupt on press and one on release.
// - Scan converts each selected channel not owned by continuous or touch mode once, in turn.
// - Watchdog flags any result above upper or below lower threshold.
// - Channels 0 and 1 are the X+ and Y+ touch inputs; 2 and 3 general.
// - Four-wire X: VREF on X+, zero on X- pad, convert Y+.
// - Four-wire Y: VREF on Y+, zero on Y- pad, convert X+.
// - Five-wire uses only Y+; X- and Y- pads drive panel corners.
// - Five-wire X: VREF bottom-left, zero top-right, convert Y+.
`timescale 1ns/10ps
`include "atc_consts.svh"

module atc_top
(
    // Clock and reset
    input wire logic clock,
    input wire logic srst,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    // Converter macro
    output logic conv_clk_en,
    output logic conv_start,
    output logic [1:0] conv_chan,
    input wire logic conv_done,
    input wire logic [9:0] conv_data,
    // DMA request
    output logic dma_req,
    output logic [11:0] dma_data,
    input wire logic dma_ack,
    // Touch panel
    input wire logic pen_down,
    output logic xp_vref_en,
    output logic yp_vref_en,
    output logic xm_pad_out,
    output logic xm_pad_oe,
    output logic ym_pad_out,
    output logic ym_pad_oe,
    // Event pulses
    output logic irq_press,
    output logic irq_release,
    output logic irq_wdog
);

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------

    // Channels owned by the running continuous or touch activity
    function automatic logic [3:0] busy_chans(input logic cont, input logic touch, input logic [1:0] ch);
        logic [3:0] m;
        m = 4'h0;
        if (cont)
            m[ch] = 1'b1;
        if (touch)
            m[1:0] = 2'h3;
        return m;
    endfunction : busy_chans

    // Lowest set bit of a channel mask
    function automatic logic [1:0] first_chan(input logic [3:0] m);
        logic [1:0] c;
        c = 2'h3;
        for (int i = 3; i >= 0; i--)
            if (m[i])
                c = 2'(i);
        return c;
    endfunction : first_chan

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    logic cont_en_reg, touch_en_reg, five_wire_reg, wd_en_reg;
    logic [1:0] single_chan_reg, cont_chan_reg;
    logic [3:0] scan_mask_reg, scan_left_reg;
    logic [15:0] conv_div_reg, intv_div_reg;
    logic [9:0] wd_lo_reg, wd_hi_reg;
    logic single_pend_reg, touch_pend_reg, cont_pend_reg, touch_y_reg, pen_q_reg;
    logic [3:0] stat_reg;
    logic [9:0] tx_reg, ty_reg;
    logic tx_valid_reg, ty_valid_reg;
    logic [9:0] res_reg [4];
    atc_pkg::atc_state_t state_reg;
    atc_pkg::atc_job_t job_reg;
    logic intv_tick, done_now, out_range, refuse;
    logic pick_go;
    atc_pkg::atc_job_t pick_job;
    logic [1:0] pick_chan;
    logic wr_ctrl, wr_stat, rd_tx, rd_ty;
    logic [3:0] in_use;

    assign wr_ctrl = reg_wr && reg_addr == `ATC_OFF_CTRL;
    assign wr_stat = reg_wr && reg_addr == `ATC_OFF_STAT;
    assign rd_tx = reg_rd && reg_addr == `ATC_OFF_TX;
    assign rd_ty = reg_rd && reg_addr == `ATC_OFF_TY;
    assign in_use = busy_chans(cont_en_reg, touch_en_reg, cont_chan_reg);
    assign done_now = state_reg == atc_pkg::ST_WAIT && conv_done;
    assign out_range = conv_data > wd_hi_reg || conv_data < wd_lo_reg;
    assign refuse = wr_ctrl && reg_wdata[`ATC_CTRL_SINGLE_GO]
        && in_use[reg_wdata[`ATC_CTRL_SINGLE_LSB +: 2]];

    // ------------------------------------------------------------------
    // Rate generation
    // ------------------------------------------------------------------
    atc_rate_div u_conv_div (
        .clock(clock),
        .srst(srst),
        .div(conv_div_reg),
        .min_div(`ATC_CONV_MIN_DIV),
        .tick(conv_clk_en)
    );

    atc_rate_div u_intv_div (
        .clock(clock),
        .srst(srst),
        .div(intv_div_reg),
        .min_div(`ATC_INTV_MIN_DIV),
        .tick(intv_tick)
    );

    // ------------------------------------------------------------------
    // Configuration registers
    // ------------------------------------------------------------------
    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            {cont_en_reg, touch_en_reg, five_wire_reg, wd_en_reg} <= 4'h0;
            single_chan_reg <= 2'h0;
            cont_chan_reg <= 2'h0;
            scan_mask_reg <= 4'h0;
            conv_div_reg <= `ATC_DIV_RST;
            intv_div_reg <= `ATC_DIV_RST;
            wd_lo_reg <= `ATC_WD_LO_RST;
            wd_hi_reg <= `ATC_WD_HI_RST;
        end
        else
        begin
            if (wr_ctrl)
            begin
                cont_en_reg <= reg_wdata[`ATC_CTRL_CONT_EN];
                touch_en_reg <= reg_wdata[`ATC_CTRL_TOUCH_EN];
                five_wire_reg <= reg_wdata[`ATC_CTRL_FIVE_WIRE];
                wd_en_reg <= reg_wdata[`ATC_CTRL_WD_EN];
                single_chan_reg <= reg_wdata[`ATC_CTRL_SINGLE_LSB +: 2];
                cont_chan_reg <= reg_wdata[`ATC_CTRL_CONT_LSB +: 2];
                scan_mask_reg <= reg_wdata[`ATC_CTRL_SCAN_LSB +: 4];
            end
            if (reg_wr && reg_addr == `ATC_OFF_CDIV)
                conv_div_reg <= reg_wdata[15:0];
            if (reg_wr && reg_addr == `ATC_OFF_IDIV)
                intv_div_reg <= reg_wdata[15:0];
            if (reg_wr && reg_addr == `ATC_OFF_WDOG)
            begin
                wd_lo_reg <= reg_wdata[9:0];
                wd_hi_reg <= reg_wdata[`ATC_WDOG_HI_LSB +: 10];
            end
        end
    end

    // ------------------------------------------------------------------
    // Job selection: touch, then continuous, then single, then scan
    // ------------------------------------------------------------------
    always_comb
    begin
        pick_go = 1'b0;
        pick_job = atc_pkg::JOB_SINGLE;
        pick_chan = 2'h0;
        if (state_reg == atc_pkg::ST_IDLE)
        begin
            if (touch_pend_reg && touch_en_reg)
            begin
                pick_go = 1'b1;
                pick_job = touch_y_reg ? atc_pkg::JOB_TOUCH_Y : atc_pkg::JOB_TOUCH_X;
                pick_chan = (touch_y_reg && !five_wire_reg) ? `ATC_CH_XP : `ATC_CH_YP;
            end
            else if (cont_pend_reg && cont_en_reg && !dma_req)
            begin
                pick_go = 1'b1;
                pick_job = atc_pkg::JOB_CONT;
                pick_chan = cont_chan_reg;
            end
            else if (single_pend_reg)
            begin
                pick_go = 1'b1;
                pick_chan = single_chan_reg;
            end
            else if (scan_left_reg != 4'h0)
            begin
                pick_go = 1'b1;
                pick_job = atc_pkg::JOB_SCAN;
                pick_chan = first_chan(scan_left_reg);
            end
        end
    end

    // ------------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------------
    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            state_reg <= atc_pkg::ST_IDLE;
            job_reg <= atc_pkg::JOB_SINGLE;
            conv_start <= 1'b0;
            conv_chan <= 2'h0;
        end
        else
        begin
            conv_start <= pick_go;
            unique case (state_reg)
                atc_pkg::ST_IDLE:
                    if (pick_go)
                    begin
                        state_reg <= atc_pkg::ST_WAIT;
                        job_reg <= pick_job;
                        conv_chan <= pick_chan;
                    end
                atc_pkg::ST_WAIT:
                    if (conv_done)
                        state_reg <= atc_pkg::ST_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Pending requests; a new request beats the clear of the same cycle
    // ------------------------------------------------------------------
    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            {single_pend_reg, touch_pend_reg, cont_pend_reg} <= 3'h0;
            scan_left_reg <= 4'h0;
        end
        else
        begin
            if (wr_ctrl && reg_wdata[`ATC_CTRL_SINGLE_GO] && !refuse)
                single_pend_reg <= 1'b1;
            else if (pick_go && pick_job == atc_pkg::JOB_SINGLE)
                single_pend_reg <= 1'b0;
            if (intv_tick && touch_en_reg && pen_q_reg)
                touch_pend_reg <= 1'b1;
            else if (pick_go && (pick_job == atc_pkg::JOB_TOUCH_X || pick_job == atc_pkg::JOB_TOUCH_Y))
                touch_pend_reg <= 1'b0;
            if (intv_tick && cont_en_reg && !touch_en_reg)
                cont_pend_reg <= 1'b1;
            else if (pick_go && pick_job == atc_pkg::JOB_CONT)
                cont_pend_reg <= 1'b0;
            // Scan skips channels the continuous activity owns
            if (wr_ctrl && reg_wdata[`ATC_CTRL_SCAN_GO])
                scan_left_reg <= reg_wdata[`ATC_CTRL_SCAN_LSB +: 4] & ~in_use;
            else if (pick_go && pick_job == atc_pkg::JOB_SCAN)
                scan_left_reg[pick_chan] <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Results: per-channel store, DMA word, touch coordinates
    // ------------------------------------------------------------------
    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            for (int i = 0; i < 4; i++)
                res_reg[i] <= 10'h000;
            dma_req <= 1'b0;
            dma_data <= 12'h000;
            tx_reg <= 10'h000;
            ty_reg <= 10'h000;
            {tx_valid_reg, ty_valid_reg, touch_y_reg} <= 3'h0;
        end
        else
        begin
            if (dma_ack)
                dma_req <= 1'b0;
            if (rd_tx)
                tx_valid_reg <= 1'b0;
            if (rd_ty)
                ty_valid_reg <= 1'b0;
            if (done_now)
            begin
                unique case (job_reg)
                    atc_pkg::JOB_SINGLE, atc_pkg::JOB_SCAN:
                        res_reg[conv_chan] <= conv_data;
                    atc_pkg::JOB_CONT:
                    begin
                        dma_req <= 1'b1;
                        dma_data <= {conv_chan, conv_data};
                    end
                    atc_pkg::JOB_TOUCH_X:
                    begin
                        // Unread coordinate is kept; a newer one is dropped
                        if (!tx_valid_reg || rd_tx)
                            tx_reg <= conv_data;
                        tx_valid_reg <= 1'b1;
                        touch_y_reg <= 1'b1;
                    end
                    atc_pkg::JOB_TOUCH_Y:
                    begin
                        if (!ty_valid_reg || rd_ty)
                            ty_reg <= conv_data;
                        ty_valid_reg <= 1'b1;
                        touch_y_reg <= 1'b0;
                    end
                endcase
            end
        end
    end

    // ------------------------------------------------------------------
    // Panel drive; pads float whenever no touch conversion is in flight
    // ------------------------------------------------------------------
    always_ff @(posedge clock)
    begin
        if (srst || done_now)
            {xp_vref_en, yp_vref_en, xm_pad_out, xm_pad_oe, ym_pad_out, ym_pad_oe} <= 6'h00;
        else if (pick_go && pick_job == atc_pkg::JOB_TOUCH_X)
        begin
            xm_pad_oe <= 1'b1;
            ym_pad_oe <= five_wire_reg;
            xp_vref_en <= !five_wire_reg;
            xm_pad_out <= five_wire_reg;
            ym_pad_out <= 1'b0;
        end
        else if (pick_go && pick_job == atc_pkg::JOB_TOUCH_Y)
        begin
            ym_pad_oe <= 1'b1;
            xm_pad_oe <= five_wire_reg;
            yp_vref_en <= !five_wire_reg;
            ym_pad_out <= five_wire_reg;
            xm_pad_out <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Events and sticky status, write one to clear, set wins
    // ------------------------------------------------------------------
    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            pen_q_reg <= 1'b0;
            {irq_press, irq_release, irq_wdog} <= 3'h0;
            stat_reg <= 4'h0;
        end
        else
        begin
            pen_q_reg <= pen_down;
            irq_press <= touch_en_reg && pen_down && !pen_q_reg;
            irq_release <= touch_en_reg && !pen_down && pen_q_reg;
            irq_wdog <= done_now && wd_en_reg && out_range;
            stat_reg <= (stat_reg & ~({4{wr_stat}} & reg_wdata[3:0]))
                | {refuse, done_now && wd_en_reg && out_range,
                   touch_en_reg && !pen_down && pen_q_reg, touch_en_reg && pen_down && !pen_q_reg};
        end
    end

    // ------------------------------------------------------------------
    // Read port: data one cycle after the strobe, unmapped reads zero
    // ------------------------------------------------------------------
    always_ff @(posedge clock)
    begin
        if (srst)
            reg_rdata <= 32'h0000_0000;
        else if (reg_rd)
        begin
            reg_rdata <= 32'h0000_0000;
            unique case (reg_addr)
                `ATC_OFF_CTRL:
                    reg_rdata <= {12'h000, scan_mask_reg, 2'h0, cont_chan_reg, 2'h0, single_chan_reg,
                                  2'h0, wd_en_reg, |scan_left_reg, five_wire_reg, touch_en_reg,
                                  cont_en_reg, single_pend_reg};
                `ATC_OFF_CDIV: reg_rdata <= {16'h0000, conv_div_reg};
                `ATC_OFF_IDIV: reg_rdata <= {16'h0000, intv_div_reg};
                `ATC_OFF_WDOG: reg_rdata <= {6'h00, wd_hi_reg, 6'h00, wd_lo_reg};
                `ATC_OFF_STAT: reg_rdata <= {26'h0000000, state_reg != atc_pkg::ST_IDLE, pen_q_reg, stat_reg};
                `ATC_OFF_TX: reg_rdata <= {tx_valid_reg, 21'h000000, tx_reg};
                `ATC_OFF_TY: reg_rdata <= {ty_valid_reg, 21'h000000, ty_reg};
                default:
                    if (reg_addr >= `ATC_OFF_RES0 && reg_addr <= `ATC_OFF_RES3 && reg_addr[1:0] == 2'h0)
                        reg_rdata <= {22'h000000, res_reg[reg_addr[3:2]]};
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking @(posedge clock); endclocking
    default disable iff (srst);

    start_pulse_a: assert property (conv_start |-> state_reg == atc_pkg::ST_WAIT ##1 !conv_start)
        else $error("start not a single pulse into wait");
    fourwire_x_a: assert property (conv_start && job_reg == atc_pkg::JOB_TOUCH_X && !five_wire_reg
        |-> xp_vref_en && xm_pad_oe && !xm_pad_out && !ym_pad_oe && conv_chan == `ATC_CH_YP)
        else $error("four-wire X drive wrong");
    fourwire_y_a: assert property (conv_start && job_reg == atc_pkg::JOB_TOUCH_Y && !five_wire_reg
        |-> yp_vref_en && ym_pad_oe && !ym_pad_out && !xm_pad_oe && conv_chan == `ATC_CH_XP)
        else $error("four-wire Y drive wrong");
    fivewire_x_a: assert property (conv_start && job_reg == atc_pkg::JOB_TOUCH_X && five_wire_reg
        |-> xm_pad_oe && xm_pad_out && ym_pad_oe && !ym_pad_out && !xp_vref_en && conv_chan == `ATC_CH_YP)
        else $error("five-wire X drive wrong");
    dma_hold_a: assert property (dma_req && !dma_ack |=> dma_req && $stable(dma_data))
        else $error("DMA word dropped before ack");
    touch_no_dma_a: assert property (done_now && job_reg inside {atc_pkg::JOB_TOUCH_X, atc_pkg::JOB_TOUCH_Y}
        && !dma_req |=> !dma_req && (tx_valid_reg || ty_valid_reg))
        else $error("touch result went to DMA");
    press_irq_a: assert property ($rose(pen_down) && touch_en_reg && !pen_q_reg |=> irq_press ##1 !irq_press)
        else $error("press event missing");
    wdog_irq_a: assert property (done_now && wd_en_reg && conv_data > wd_hi_reg |=> irq_wdog && stat_reg[2])
        else $error("watchdog miss above upper threshold");
    refuse_busy_a: assert property (refuse |=> !single_pend_reg || $past(single_pend_reg))
        else $error("single accepted on owned channel");
    tx_hold_a: assert property (tx_valid_reg && !rd_tx |=> tx_valid_reg && $stable(tx_reg))
        else $error("touch X lost before read");

    cov_touch_c: cover property (done_now && job_reg == atc_pkg::JOB_TOUCH_X ##[1:1000] done_now && job_reg == atc_pkg::JOB_TOUCH_Y);
    cov_dma_c: cover property (dma_req ##[1:20] dma_ack);
    cov_scan_c: cover property (pick_go && pick_job == atc_pkg::JOB_SCAN ##[1:100] pick_go && pick_job == atc_pkg::JOB_SCAN);

endmodule : atc_top

// [atc_top_tb.sv]
// Self-checking bench for the converter/touch controller.
// Assumes the register port answers reads one cycle after the strobe.
`timescale 1ns/10ps
`include "atc_consts.svh"

module atc_top_tb;
    logic clock = 1'b0;
    logic srst = 1'b1;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic pen_down = 1'b0;
    logic [31:0] reg_rdata;
    logic conv_start, conv_done, dma_req, dma_ack, xp_vref_en, xm_pad_out, xm_pad_oe;
    logic [1:0] conv_chan;
    logic [11:0] dma_data;
    logic [9:0] conv_data;
    int n_mismatch = 0;
    int num_checks = 0;

    always #4 clock = ~clock;

    atc_top atc_top_inst (.clock(clock), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .conv_clk_en(), .conv_start(conv_start),
        .conv_chan(conv_chan), .conv_done(conv_done), .conv_data(conv_data), .dma_req(dma_req),
        .dma_data(dma_data), .dma_ack(dma_ack), .pen_down(pen_down), .xp_vref_en(xp_vref_en), .yp_vref_en(),
        .xm_pad_out(xm_pad_out), .xm_pad_oe(xm_pad_oe), .ym_pad_out(), .ym_pad_oe(),
        .irq_press(), .irq_release(), .irq_wdog());
    atc_conv_model atc_conv_model_inst (.clock(clock), .conv_start(conv_start), .conv_chan(conv_chan),
        .conv_done(conv_done), .conv_data(conv_data), .dma_req(dma_req), .dma_ack(dma_ack));

    // ---------------------------------------------------------------
    // Bus tasks and checks
    // ---------------------------------------------------------------
    task automatic cmp(input string name, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask : cmp

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= d;
        @(posedge clock);
        reg_wr <= 1'b0;
    endtask : wr

    // Read data appear in the cycle after the strobe and hold until the next read
    task automatic rd(input string name, input logic [7:0] a, input logic [31:0] exp, input logic [31:0] m);
        @(posedge clock);
        reg_rd <= 1'b1; reg_addr <= a;
        @(posedge clock);
        reg_rd <= 1'b0;
        #1 cmp(name, exp & m, reg_rdata & m);
    endtask : rd

    // Bounded wait for the converter answer
    task automatic wait_done();
        for (int i = 0; i < 400 && conv_done !== 1'b1; i++) @(posedge clock);
        @(posedge clock);
    endtask : wait_done

    // Bounded wait for a start; pads and channel stand until the done
    task automatic wait_start();
        for (int i = 0; i < 400 && conv_start !== 1'b1; i++) @(posedge clock);
    endtask : wait_start

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : wrap_up

    // Hang guard, far above the expected run length
    initial
    begin
        repeat (20000) @(posedge clock);
        n_mismatch++;
        wrap_up();
    end

    // ---------------------------------------------------------------
    // Tests
    // ---------------------------------------------------------------
    initial
    begin
        repeat (20) @(posedge clock);
        srst <= 1'b0;
        rd("wdog_rst", `ATC_OFF_WDOG, 32'h03ff0000, 32'h03ff03ff);
        rd("unmapped", 8'h3c, 32'h0, 32'hffffffff);
        $display("reset test done");
        wr(`ATC_OFF_CDIV, 32'h8);
        wr(`ATC_OFF_WDOG, 32'h02000100);
        wr(`ATC_OFF_CTRL, 32'h221);
        wait_done();
        rd("res2", 8'h28, 32'h2a5, 32'h3ff);
        rd("stat_wd", `ATC_OFF_STAT, 32'h4, 32'h4);
        $display("single test done");
        wr(`ATC_OFF_IDIV, 32'h7d);
        wr(`ATC_OFF_CTRL, 32'h4);
        // Press only counts once touch mode is on
        pen_down <= 1'b1;
        wait_start();
        cmp("xp_vref", 32'h1, {31'h0, xp_vref_en});
        cmp("xm_pad", 32'h1, {30'h0, xm_pad_out, xm_pad_oe});
        cmp("x_chan", 32'h1, {30'h0, conv_chan});
        wait_done();
        rd("tx", `ATC_OFF_TX, 32'h800001a5, 32'h800003ff);
        rd("press", `ATC_OFF_STAT, 32'h1, 32'h1);
        $display("touch test done");
        wr(`ATC_OFF_CTRL, 32'h3002);
        wr(`ATC_OFF_CTRL, 32'h3303);
        rd("refused", `ATC_OFF_STAT, 32'h8, 32'h8);
        for (int i = 0; i < 400 && dma_req !== 1'b1; i++) @(posedge clock);
        cmp("dma_word", 32'hfa5, {20'h0, dma_data});
        $display("continuous test done");
        wr(`ATC_OFF_CTRL, 32'hc);
        wait_start();
        cmp("fw_y_pad", 32'h1, {30'h0, xm_pad_out, xm_pad_oe});
        cmp("fw_y_chan", 32'h1, {30'h0, conv_chan});
        wait_done();
        wait_start();
        cmp("fw_x_pad", 32'h3, {30'h0, xm_pad_out, xm_pad_oe});
        cmp("fw_x_chan", 32'h1, {30'h0, conv_chan});
        $display("five-wire test done");
        wrap_up();
    end
endmodule : atc_top_tb
